// >>> hw/csc_pkg.sv
// Purpose: Shared constants for the calibration session controller
// Assumes: 32-bit Avalon-MM register bus, byte addresses, 200 MHz clock
// Notes:   Offsets are byte addresses of aligned words
package csc_pkg;
    // Register byte offsets
    localparam logic [7:0] CSC_CMD_OFS    = 8'h00;
    localparam logic [7:0] CSC_ARG_OFS    = 8'h04;
    localparam logic [7:0] CSC_MODE_OFS   = 8'h08;
    localparam logic [7:0] CSC_ERR_OFS    = 8'h0c;
    localparam logic [7:0] CSC_STAT_OFS   = 8'h10;
    localparam logic [7:0] CSC_IRQ_OFS    = 8'h14;
    localparam logic [7:0] CSC_MASK_OFS   = 8'h18;
    localparam logic [7:0] CSC_VLO_OFS    = 8'h1c;
    localparam logic [7:0] CSC_VHI_OFS    = 8'h20;
    localparam logic [7:0] CSC_ILO_OFS    = 8'h24;
    localparam logic [7:0] CSC_IHI_OFS    = 8'h28;
    localparam logic [7:0] CSC_OVK_OFS    = 8'h2c;
    localparam logic [7:0] CSC_PASS_OFS   = 8'h30;
    localparam logic [7:0] CSC_NVVLO_OFS  = 8'h34;
    localparam logic [7:0] CSC_NVVHI_OFS  = 8'h38;
    localparam logic [7:0] CSC_NVILO_OFS  = 8'h3c;
    localparam logic [7:0] CSC_NVIHI_OFS  = 8'h40;
    // Command codes written to the command register
    localparam logic [3:0] CSC_C_MODE_OFF = 4'h0;
    localparam logic [3:0] CSC_C_MODE_ON  = 4'h1;
    localparam logic [3:0] CSC_C_PASS     = 4'h2;
    localparam logic [3:0] CSC_C_VSEL_LO  = 4'h3;
    localparam logic [3:0] CSC_C_VSEL_HI  = 4'h4;
    localparam logic [3:0] CSC_C_VDATA    = 4'h5;
    localparam logic [3:0] CSC_C_ISEL_LO  = 4'h6;
    localparam logic [3:0] CSC_C_ISEL_HI  = 4'h7;
    localparam logic [3:0] CSC_C_IDATA    = 4'h8;
    localparam logic [3:0] CSC_C_OVCAL    = 4'h9;
    localparam logic [3:0] CSC_C_SAVE     = 4'ha;
    // Command word layout: bit 4 marks password supplied
    localparam int         CSC_PW_GIVEN_BIT = 4;
    // Error codes
    localparam logic [2:0] CSC_E_LOCK     = 3'h1;
    localparam logic [2:0] CSC_E_PASS     = 3'h2;
    localparam logic [2:0] CSC_E_MODE     = 3'h3;
    localparam logic [2:0] CSC_E_RDBK     = 3'h4;
    localparam logic [2:0] CSC_E_PROG     = 3'h5;
    localparam logic [2:0] CSC_E_SEQ      = 3'h6;
    localparam logic [2:0] CSC_E_STATE    = 3'h7;
    // Interrupt bit positions
    localparam int         CSC_S_ERR      = 0;
    localparam int         CSC_S_VDONE    = 1;
    localparam int         CSC_S_IDONE    = 2;
    localparam int         CSC_S_OVDONE   = 3;
    localparam int         CSC_S_SAVED    = 4;
    localparam int         CSC_NIRQ       = 5;
    // Password reset value and unmapped-address read value
    localparam logic [31:0] CSC_PASS_RST  = 32'h0000_0000;
    localparam logic [31:0] CSC_UNMAPPED  = 32'h0000_0000;
    // Overvoltage calibration run time
    localparam int         CSC_CLK_MHZ    = 200;
    localparam int         CSC_OV_MS      = 3;
    localparam int         CSC_OV_CYC     = CSC_OV_MS * 1000 * CSC_CLK_MHZ;
    // Error queue depth
    localparam int         CSC_EQ_DEPTH   = 8;
    // Pass-point state, Gray along low then high
    typedef enum logic [1:0] {
        CSC_P_IDLE   = 2'b00,
        CSC_P_LO_SEL = 2'b01,
        CSC_P_LO_OK  = 2'b11,
        CSC_P_HI_SEL = 2'b10
    } csc_pt_t;
endpackage

// >>> hw/csc_errq.sv
// Purpose: Small error-code queue with registered head
// Assumes: Push and pop are single-cycle pulses
// Notes:   Push while full drops the new code
`timescale 1ns/1ps
module csc_errq #(
    parameter int DEPTH = 8
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       push_in,
    input  wire logic [2:0] code_in,
    input  wire logic       pop_in,
    output logic      [2:0] head_out,
    output logic            empty_out
);
    localparam int AW = $clog2(DEPTH);
    logic [2:0]  mem_r [DEPTH];
    logic [AW:0] wp_r, rp_r, wp_nxt, rp_nxt;
    logic        full;

    // Pointer arithmetic with wrap bit
    always_comb begin
        full   = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
        wp_nxt = (push_in && !full) ? wp_r + 1'b1 : wp_r;
        rp_nxt = (pop_in && !empty_out) ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clock_in) begin
        if (push_in && !full) begin
            mem_r[wp_r[AW-1:0]] <= code_in;
        end
    end

    // Registered head; empty head reads zero
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            head_out  <= 3'h0;
            empty_out <= 1'b1;
        end else begin
            empty_out <= (wp_nxt == rp_nxt);
            head_out  <= (wp_nxt == rp_nxt) ? 3'h0 :
                         ((wp_r == rp_nxt) ? code_in : mem_r[rp_nxt[AW-1:0]]);
        end
    end
endmodule

// >>> hw/csc_top.sv
// Purpose: Calibration session command handler on an Avalon-MM slave
// Assumes: Analog front end supplies regulation state and OV result
// Notes:   Commands are written as words to the command register
// Functional notes
// - Commands other than enable and disable refused while off, error 3
// - Nonzero password must match, else error 2
// - Mode query returns only 0 or 1
// - Leaving mode drops unsaved constants
// - Password change only while mode is on
// - New password stored to nonvolatile at once
// - Zero password enables without a password check; lockout still refuses
// - Current constants computed after low and high
// - Voltage constants computed after both ends
// - Low point first, else sequence error 6
// - Constants saved to nonvolatile only on save
// - OV calibration needs voltage done, on, CV
// - OV calibration autonomous, stores result directly
// - Range errors: readback 4, programming 5
// - Lockout input refuses enable, error 1
// - Point select needs matching regulation mode
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module csc_top
    import csc_pkg::*;
#(
    parameter int OV_CYCLES = csc_pkg::CSC_OV_CYC,
    parameter logic [31:0] VAL_MAX = 32'h00ff_ffff
) (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        cal_lockout_in,
    input  wire logic        output_enabled_in,
    input  wire logic        constant_voltage_regulation_in,
    input  wire logic        constant_current_regulation_in,
    input  wire logic        ov_range_ok_in,
    output logic             cal_mode_out,
    output logic             ov_cal_busy_out,
    output logic             irq_out
);
    import csc_pkg::*;

    // Registered state
    logic        mode_r, mode_nxt;
    logic [31:0] arg_r, arg_nxt;
    logic [31:0] pass_r, pass_nxt;
    logic [31:0] vlo_r, vhi_r, ilo_r, ihi_r, ovk_r;
    logic [31:0] vlo_nxt, vhi_nxt, ilo_nxt, ihi_nxt, ovk_nxt;
    logic [31:0] nvvlo_r, nvvhi_r, nvilo_r, nvihi_r;
    logic [31:0] nvvlo_nxt, nvvhi_nxt, nvilo_nxt, nvihi_nxt;
    logic        vdone_r, vdone_nxt, idone_r, idone_nxt;
    csc_pt_t     vpt_r, vpt_nxt, ipt_r, ipt_nxt;
    logic [31:0] ovcnt_r, ovcnt_nxt;
    logic [CSC_NIRQ-1:0] irq_r, irq_nxt, mask_r, mask_nxt, ev;
    logic        ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // Error queue handshake
    logic        epush, epop, eempty;
    logic [2:0]  ecode, ehead;
    logic        wr_cmd, cmd_pw;
    logic [3:0]  cmd;

    // Single-cycle wait so every access answers on the second edge
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_r;
    assign wr_cmd  = avs_write_in && ack_r && (avs_address_in == CSC_CMD_OFS);
    assign cmd     = avs_writedata_in[3:0];
    assign cmd_pw  = avs_writedata_in[CSC_PW_GIVEN_BIT];
    assign epop    = avs_read_in && ack_r && (avs_address_in == CSC_ERR_OFS);
    assign cal_mode_out    = mode_r;
    assign ov_cal_busy_out = (ovcnt_r != 32'h0);
    assign irq_out         = |(irq_r & mask_r);

    // Command interpreter
    always_comb begin
        mode_nxt = mode_r; pass_nxt = pass_r; arg_nxt = arg_r;
        vlo_nxt = vlo_r; vhi_nxt = vhi_r; ilo_nxt = ilo_r; ihi_nxt = ihi_r; ovk_nxt = ovk_r;
        nvvlo_nxt = nvvlo_r; nvvhi_nxt = nvvhi_r; nvilo_nxt = nvilo_r; nvihi_nxt = nvihi_r;
        vdone_nxt = vdone_r; idone_nxt = idone_r; vpt_nxt = vpt_r; ipt_nxt = ipt_r;
        ovcnt_nxt = ovcnt_r; epush = 1'b0; ecode = 3'h0; ev = '0;
        ack_nxt = (avs_read_in || avs_write_in) && !ack_r;
        // Overvoltage run counts down on its own; result stored directly
        if (ovcnt_r != 32'h0) begin
            ovcnt_nxt = ovcnt_r - 32'h1;
            if (ovcnt_r == 32'h1) begin
                if (!constant_voltage_regulation_in || !ov_range_ok_in) begin
                    epush = 1'b1;
                    ecode = constant_voltage_regulation_in ? CSC_E_PROG : CSC_E_STATE;
                end else begin
                    ovk_nxt = arg_r;
                    ev[CSC_S_OVDONE] = 1'b1;
                end
            end
        end
        if (avs_write_in && ack_r && avs_address_in == CSC_ARG_OFS) begin
            arg_nxt = avs_writedata_in;
        end
        if (wr_cmd && ovcnt_r == 32'h0) begin
            if (cmd == CSC_C_MODE_ON) begin
                if (cal_lockout_in) begin
                    epush = 1'b1; ecode = CSC_E_LOCK;
                end else if (pass_r == 32'h0) begin
                    mode_nxt = 1'b1;
                end else if (cmd_pw && arg_r == pass_r) begin
                    mode_nxt = 1'b1;
                end else begin
                    epush = 1'b1; ecode = CSC_E_PASS;
                end
            end else if (cmd == CSC_C_MODE_OFF) begin
                mode_nxt = 1'b0;
            end else if (!mode_r) begin
                epush = 1'b1; ecode = CSC_E_MODE;
            end else begin
                unique case (cmd)
                    CSC_C_PASS: begin
                        pass_nxt = arg_r;
                    end
                    CSC_C_VSEL_LO, CSC_C_VSEL_HI: begin
                        if (!constant_voltage_regulation_in) begin
                            epush = 1'b1; ecode = CSC_E_STATE;
                        end else if (cmd == CSC_C_VSEL_LO) begin
                            vpt_nxt = CSC_P_LO_SEL;
                        end else if (vpt_r == CSC_P_LO_OK) begin
                            vpt_nxt = CSC_P_HI_SEL;
                        end else begin
                            epush = 1'b1; ecode = CSC_E_SEQ;
                        end
                    end
                    CSC_C_ISEL_LO, CSC_C_ISEL_HI: begin
                        if (!constant_current_regulation_in) begin
                            epush = 1'b1; ecode = CSC_E_STATE;
                        end else if (cmd == CSC_C_ISEL_LO) begin
                            ipt_nxt = CSC_P_LO_SEL;
                        end else if (ipt_r == CSC_P_LO_OK) begin
                            ipt_nxt = CSC_P_HI_SEL;
                        end else begin
                            epush = 1'b1; ecode = CSC_E_SEQ;
                        end
                    end
                    CSC_C_VDATA: begin
                        if (vpt_r == CSC_P_LO_SEL) begin
                            vlo_nxt = arg_r; vpt_nxt = CSC_P_LO_OK;
                        end else if (vpt_r == CSC_P_HI_SEL) begin
                            vpt_nxt = CSC_P_IDLE;
                            if (arg_r > VAL_MAX || arg_r <= vlo_r) begin
                                epush = 1'b1;
                                ecode = (arg_r > VAL_MAX) ? CSC_E_PROG : CSC_E_RDBK;
                            end else begin
                                vhi_nxt = arg_r; vdone_nxt = 1'b1;
                                ev[CSC_S_VDONE] = 1'b1;
                            end
                        end else begin
                            epush = 1'b1; ecode = CSC_E_SEQ;
                        end
                    end
                    CSC_C_IDATA: begin
                        if (ipt_r == CSC_P_LO_SEL) begin
                            ilo_nxt = arg_r; ipt_nxt = CSC_P_LO_OK;
                        end else if (ipt_r == CSC_P_HI_SEL) begin
                            ipt_nxt = CSC_P_IDLE;
                            if (arg_r > VAL_MAX || arg_r <= ilo_r) begin
                                epush = 1'b1;
                                ecode = (arg_r > VAL_MAX) ? CSC_E_PROG : CSC_E_RDBK;
                            end else begin
                                ihi_nxt = arg_r; idone_nxt = 1'b1;
                                ev[CSC_S_IDONE] = 1'b1;
                            end
                        end else begin
                            epush = 1'b1; ecode = CSC_E_SEQ;
                        end
                    end
                    CSC_C_OVCAL: begin
                        if (vdone_r && output_enabled_in && constant_voltage_regulation_in) begin
                            ovcnt_nxt = 32'(OV_CYCLES);
                        end else begin
                            epush = 1'b1; ecode = CSC_E_STATE;
                        end
                    end
                    CSC_C_SAVE: begin
                        if (vdone_r) begin
                            nvvlo_nxt = vlo_r; nvvhi_nxt = vhi_r;
                        end
                        if (idone_r) begin
                            nvilo_nxt = ilo_r; nvihi_nxt = ihi_r;
                        end
                        ev[CSC_S_SAVED] = 1'b1;
                    end
                    default: begin
                        epush = 1'b1; ecode = CSC_E_SEQ;
                    end
                endcase
            end
        end
        // Leaving the mode discards unsaved constants
        if (mode_r && !mode_nxt) begin
            vlo_nxt = nvvlo_r; vhi_nxt = nvvhi_r; ilo_nxt = nvilo_r; ihi_nxt = nvihi_r;
            vdone_nxt = 1'b0; idone_nxt = 1'b0;
            vpt_nxt = CSC_P_IDLE; ipt_nxt = CSC_P_IDLE;
        end
        ev[CSC_S_ERR] = epush;
        // Set wins over write-one-to-clear
        mask_nxt = mask_r;
        irq_nxt  = irq_r;
        if (avs_write_in && ack_r && avs_address_in == CSC_IRQ_OFS && avs_byteenable_in[0]) begin
            irq_nxt = irq_r & ~avs_writedata_in[CSC_NIRQ-1:0];
        end
        if (avs_write_in && ack_r && avs_address_in == CSC_MASK_OFS && avs_byteenable_in[0]) begin
            mask_nxt = avs_writedata_in[CSC_NIRQ-1:0];
        end
        irq_nxt = irq_nxt | ev;
    end

    // Read mux, data registered on the wait cycle
    always_comb begin
        rdata_nxt = CSC_UNMAPPED;
        unique case (avs_address_in)
            CSC_ARG_OFS:   rdata_nxt = arg_r;
            CSC_MODE_OFS:  rdata_nxt = {31'h0, mode_r};
            CSC_ERR_OFS:   rdata_nxt = {29'h0, ehead};
            CSC_STAT_OFS:  rdata_nxt = {26'h0, ov_cal_busy_out, vdone_r, idone_r,
                                        vpt_r == CSC_P_HI_SEL, ipt_r == CSC_P_HI_SEL, !eempty};
            CSC_IRQ_OFS:   rdata_nxt = {27'h0, irq_r};
            CSC_MASK_OFS:  rdata_nxt = {27'h0, mask_r};
            CSC_VLO_OFS:   rdata_nxt = vlo_r;
            CSC_VHI_OFS:   rdata_nxt = vhi_r;
            CSC_ILO_OFS:   rdata_nxt = ilo_r;
            CSC_IHI_OFS:   rdata_nxt = ihi_r;
            CSC_OVK_OFS:   rdata_nxt = ovk_r;
            CSC_NVVLO_OFS: rdata_nxt = nvvlo_r;
            CSC_NVVHI_OFS: rdata_nxt = nvvhi_r;
            CSC_NVILO_OFS: rdata_nxt = nvilo_r;
            CSC_NVIHI_OFS: rdata_nxt = nvihi_r;
            default:       rdata_nxt = CSC_UNMAPPED;
        endcase
    end

    // State registers; reset leaves the mode off
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mode_r <= 1'b0;
            pass_r <= CSC_PASS_RST; arg_r <= 32'h0;
            vlo_r <= 32'h0; vhi_r <= 32'h0; ilo_r <= 32'h0; ihi_r <= 32'h0; ovk_r <= 32'h0;
            nvvlo_r <= 32'h0; nvvhi_r <= 32'h0; nvilo_r <= 32'h0; nvihi_r <= 32'h0;
            vdone_r <= 1'b0; idone_r <= 1'b0; vpt_r <= CSC_P_IDLE; ipt_r <= CSC_P_IDLE;
            ovcnt_r <= 32'h0; irq_r <= '0; mask_r <= '0; ack_r <= 1'b0;
            avs_readdata_out <= 32'h0;
        end else begin
            mode_r <= mode_nxt; pass_r <= pass_nxt; arg_r <= arg_nxt;
            vlo_r <= vlo_nxt; vhi_r <= vhi_nxt; ilo_r <= ilo_nxt; ihi_r <= ihi_nxt; ovk_r <= ovk_nxt;
            nvvlo_r <= nvvlo_nxt; nvvhi_r <= nvvhi_nxt; nvilo_r <= nvilo_nxt; nvihi_r <= nvihi_nxt;
            vdone_r <= vdone_nxt; idone_r <= idone_nxt; vpt_r <= vpt_nxt; ipt_r <= ipt_nxt;
            ovcnt_r <= ovcnt_nxt; irq_r <= irq_nxt; mask_r <= mask_nxt; ack_r <= ack_nxt;
            avs_readdata_out <= rdata_nxt;
        end
    end

    // Error codes held for one-by-one readback
    csc_errq #(.DEPTH(CSC_EQ_DEPTH)) u_errq (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .push_in   (epush),
        .code_in   (ecode),
        .pop_in    (epop),
        .head_out  (ehead),
        .empty_out (eempty)
    );

    // Checks
    a_off_refuses: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_cmd && !mode_r && ovcnt_r == 0 && cmd > CSC_C_MODE_ON |-> epush && ecode == CSC_E_MODE)
        else $error("command accepted while mode off");
    a_bad_pass: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_cmd && !mode_r && ovcnt_r == 0 && cmd == CSC_C_MODE_ON && !cal_lockout_in && pass_r != 0
        && arg_r != pass_r |=> !mode_r && $past(epush))
        else $error("wrong password enabled mode");
    a_mode_query: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(ack_r) && avs_read_in && avs_address_in == CSC_MODE_OFS |=> avs_readdata_out[31:1] == 0)
        else $error("mode query leaks bits");
    a_drop_unsaved: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(mode_r) |-> vlo_r == nvvlo_r && ihi_r == nvihi_r && !vdone_r)
        else $error("unsaved constants kept");
    a_pass_store: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_cmd && mode_r && ovcnt_r == 0 && cmd == CSC_C_PASS |=> pass_r == $past(arg_r))
        else $error("password not stored");
    a_zero_pass: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_cmd && ovcnt_r == 0 && cmd == CSC_C_MODE_ON && !cal_lockout_in && pass_r == 0 |=> mode_r)
        else $error("zero password did not enable");
    a_seq_order: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_cmd && mode_r && ovcnt_r == 0 && cmd == CSC_C_VSEL_HI && constant_voltage_regulation_in
        && vpt_r != CSC_P_LO_OK |-> ecode == CSC_E_SEQ)
        else $error("high point before low accepted");
    a_save_only: assert property (@(posedge clock_in) disable iff (rst_in)
        nvvlo_r != $past(nvvlo_r) |-> $past(wr_cmd && cmd == CSC_C_SAVE))
        else $error("nonvolatile changed without save");
    a_ov_guard: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(ov_cal_busy_out) |-> $past(vdone_r && output_enabled_in && constant_voltage_regulation_in))
        else $error("overvoltage run started illegally");
    a_lock_out: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_cmd && ovcnt_r == 0 && cmd == CSC_C_MODE_ON && cal_lockout_in |-> ecode == CSC_E_LOCK ##1 !$rose(mode_r))
        else $error("lockout ignored");
    a_sel_mode: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_cmd && mode_r && ovcnt_r == 0 && cmd == CSC_C_ISEL_LO && !constant_current_regulation_in
        |-> ecode == CSC_E_STATE)
        else $error("current select outside current regulation");
    c_enable: cover property (@(posedge clock_in) $rose(mode_r));
    c_vdone: cover property (@(posedge clock_in) $rose(vdone_r));
    c_ovdone: cover property (@(posedge clock_in) ev[CSC_S_OVDONE]);
    c_err_read: cover property (@(posedge clock_in) epop && !eempty);
endmodule

// >>> verification/csc_ctrl_model.sv
// Purpose: Remote controller model issuing Avalon-MM word cycles
// Assumes: Slave answers by dropping waitrequest
// Notes:   Bounded waiting is left to the bench watchdog
`timescale 1ns/1ps
module csc_ctrl_model (
    input  wire logic        clock_in,
    input  wire logic        waitrequest_in,
    output logic      [7:0]  address_out,
    output logic             read_out,
    output logic             write_out,
    output logic      [31:0] writedata_out
);
    initial begin
        address_out = 8'h00;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = 32'h0;
    end
    // Hold request until waitrequest seen low, then release
    task automatic cycle(input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        address_out <= a;
        writedata_out <= d;
        read_out <= r;
        write_out <= ~r;
        @(posedge clock_in);
        while (waitrequest_in) @(posedge clock_in);
        read_out <= 1'b0;
        write_out <= 1'b0;
        writedata_out <= ~d; // Stale data not left on the bus
    endtask
endmodule

// >>> verification/test_calibration_session_control.sv
// Purpose: Self-checking bench for the calibration session controller
// Assumes: Controller model issues every bus cycle
// Notes:   Short OV run through OV_CYCLES
`timescale 1ns/1ps
module test_calibration_session_control;
    import csc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        lock = 1'b0;
    logic        cv = 1'b0;
    logic        cc = 1'b0;
    logic        oen = 1'b1;
    logic        ovok = 1'b1;
    logic        rd_s, wr_s, wreq, busy, irq, mode;
    logic [7:0]  adr;
    logic [31:0] wd, rdat, lo, hi;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'd95877;
    int          errors = 0;
    int          cmp_count = 0;
    always #2.5 clk = ~clk;
    csc_ctrl_model u_ctrl (.clock_in(clk), .waitrequest_in(wreq), .address_out(adr), .read_out(rd_s),
        .write_out(wr_s), .writedata_out(wd));
    csc_top #(.OV_CYCLES(10)) u_dut (.clock_in(clk), .rst_in(rst), .avs_address_in(adr), .avs_read_in(rd_s),
        .avs_write_in(wr_s), .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .cal_lockout_in(lock), .output_enabled_in(oen),
        .constant_voltage_regulation_in(cv), .constant_current_regulation_in(cc), .ov_range_ok_in(ovok),
        .cal_mode_out(mode), .ov_cal_busy_out(busy), .irq_out(irq));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_ctrl.cycle(1'b1, a, 32'h0);
    endtask
    task automatic cmd(input logic [4:0] c, input logic [31:0] a);
        u_ctrl.cycle(1'b0, CSC_ARG_OFS, a);
        u_ctrl.cycle(1'b0, CSC_CMD_OFS, {27'h0, c});
    endtask
    task automatic err(input logic [2:0] c);
        rd(CSC_ERR_OFS, {29'h0, c});
        rd(CSC_ERR_OFS, 32'h0);
    endtask
    // Two-point entry, low point first
    task automatic pt(input logic [3:0] s, input logic [31:0] l, input logic [31:0] h);
        cmd({1'b0, s}, 32'h0);
        cmd({1'b0, s + 4'h2}, l);
        cmd({1'b0, s + 4'h1}, 32'h0);
        cmd({1'b0, s + 4'h2}, h);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Read results land here, oldest note first
    always @(posedge clk) begin
        if (rd_s && !wreq) begin
            chk($sformatf("reg %h", adr), exp_q.pop_front(), rdat);
        end
    end
    initial begin
        repeat (6000) @(posedge clk);
        errors++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(CSC_MODE_OFS, 32'h0);
        rd(8'h44, 32'h0);
        u_ctrl.cycle(1'b0, CSC_MASK_OFS, 32'h1);
        cmd(5'(CSC_C_VSEL_LO), 32'h0);
        err(CSC_E_MODE);
        cmd(5'(CSC_C_PASS), 32'h5a);
        err(CSC_E_MODE);
        chk("irq", 32'h1, {31'h0, irq});
        u_ctrl.cycle(1'b0, CSC_IRQ_OFS, 32'h1);
        @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        lock <= 1'b1;
        cmd(5'(CSC_C_MODE_ON), 32'h0);
        err(CSC_E_LOCK);
        lock <= 1'b0;
        cmd(5'(CSC_C_MODE_ON), 32'h0);
        rd(CSC_MODE_OFS, 32'h1);
        chk("mode", 32'h1, {31'h0, mode});
        cmd(5'(CSC_C_PASS), 32'h5a);
        cmd(5'(CSC_C_MODE_OFF), 32'h0);
        cmd(5'h10 | 5'(CSC_C_MODE_ON), 32'h5b);
        err(CSC_E_PASS);
        cmd(5'(CSC_C_MODE_ON), 32'h5a);
        err(CSC_E_PASS);
        rd(CSC_MODE_OFS, 32'h0);
        cmd(5'h10 | 5'(CSC_C_MODE_ON), 32'h5a);
        rd(CSC_MODE_OFS, 32'h1);
        $display("done: mode entry");
        cv <= 1'b1;
        cmd(5'(CSC_C_VSEL_HI), 32'h0);
        err(CSC_E_SEQ);
        cmd(5'(CSC_C_ISEL_LO), 32'h0);
        err(CSC_E_STATE);
        seed = xs(seed);
        lo = {16'h0, seed[15:0]} + 32'h1;
        hi = lo + {24'h0, seed[23:16]} + 32'h1;
        pt(CSC_C_VSEL_LO, lo, hi);
        rd(CSC_VLO_OFS, lo);
        rd(CSC_NVVLO_OFS, 32'h0);
        cmd(5'(CSC_C_MODE_OFF), 32'h0);
        cmd(5'h10 | 5'(CSC_C_MODE_ON), 32'h5a);
        rd(CSC_VHI_OFS, 32'h0);
        pt(CSC_C_VSEL_LO, lo, hi);
        cmd(5'(CSC_C_SAVE), 32'h0);
        rd(CSC_NVVHI_OFS, hi);
        $display("done: voltage points");
        cmd(5'(CSC_C_OVCAL), 32'h77);
        @(posedge clk);
        chk("busy", 32'h1, {31'h0, busy});
        repeat (40) if (busy) @(posedge clk);
        rd(CSC_OVK_OFS, 32'h77);
        ovok <= 1'b0;
        cmd(5'(CSC_C_OVCAL), 32'h55);
        @(posedge clk);
        repeat (40) if (busy) @(posedge clk);
        err(CSC_E_PROG);
        rd(CSC_OVK_OFS, 32'h77);
        ovok <= 1'b1;
        oen <= 1'b0;
        cmd(5'(CSC_C_OVCAL), 32'h0);
        err(CSC_E_STATE);
        oen <= 1'b1;
        cv <= 1'b0;
        cmd(5'(CSC_C_OVCAL), 32'h0);
        repeat (40) if (busy) @(posedge clk);
        err(CSC_E_STATE);
        cc <= 1'b1;
        pt(CSC_C_ISEL_LO, lo, hi);
        rd(CSC_IHI_OFS, hi);
        $display("done: ov and current");
        cc <= 1'b0;
        cv <= 1'b1;
        pt(CSC_C_VSEL_LO, lo, 32'hffff_ffff);
        err(CSC_E_PROG);
        pt(CSC_C_VSEL_LO, hi, lo);
        err(CSC_E_RDBK);
        $display("done: range checks");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(CSC_MODE_OFS, 32'h0);
        chk("mode", 32'h0, {31'h0, mode});
        $display("done: command reset");
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule
